// File: sli_led_model.sv
// board model of the four open-drain indicator pins
`timescale 1ns/1ps
`default_nettype none
module sli_led_model (
  // drive enables from the block
  input wire logic link_oe,
  input wire logic bus_oe,
  input wire logic net_oe,
  input wire logic node_oe,
  // pin levels, pulled high by the board when released
  output logic link_pin,
  output logic bus_pin,
  output logic net_pin,
  output logic node_pin
);
  assign link_pin = link_oe ? 1'b0 : 1'b1;
  assign bus_pin = bus_oe ? 1'b0 : 1'b1;
  assign net_pin = net_oe ? 1'b0 : 1'b1;
  assign node_pin = node_oe ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

// File: sli_map.svh
// register offsets, field positions, reset values and timing counts
`ifndef SLI_MAP_SVH
`define SLI_MAP_SVH
`define SLI_OFF_CTRL 5'h00
`define SLI_OFF_STATUS 5'h04
`define SLI_OFF_MASK 5'h08
`define SLI_OFF_IRQ 5'h0C
`define SLI_CTRL_SEL0 0
`define SLI_CTRL_VAL0 1
`define SLI_CTRL_SEL1 2
`define SLI_CTRL_VAL1 3
`define SLI_CTRL_RST 4'h0
`define SLI_MASK_RST 4'h0
`define SLI_IRQ_WAKE 0
`define SLI_IRQ_LINK 1
`define SLI_IRQ_SLEEP 2
`define SLI_IRQ_TEST 3
`define SLI_PULSE_NS 6000000
`define SLI_CLK_NS 10
`define SLI_PULSE_CYC (`SLI_PULSE_NS / `SLI_CLK_NS)
`endif

// File: sli_pkg.sv
// types of the status indicator block
package sli_pkg;
  typedef enum logic [2:0] {
    SLI_RUN = 3'b001,
    SLI_STANDBY = 3'b010,
    SLI_SCAN = 3'b100
  } sli_mode_t;
endpackage

// File: sli_top.sv
// status indicators, activity leds, wakeup and sleep/test mode logic
//
// The placing of the registers and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "sli_map.svh"
module sli_top #(
  parameter int unsigned PULSE_CYC = `SLI_PULSE_CYC
) (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RESET,
  // axi4-lite write
  input wire logic [4:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  // axi4-lite read
  input wire logic [4:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  // events from receiver, transmitter, collision detector and bus
  input wire logic LINK_PULSES_OK,
  input wire logic RX_BUS_ACCESS,
  input wire logic RX_PACKET,
  input wire logic RX_OWN_PACKET,
  input wire logic TX_PACKET,
  input wire logic COLLISION,
  input wire logic RX_LINE_ACTIVE,
  input wire logic WAKE_FRAME,
  // mode inputs
  input wire logic SLEEP_N,
  input wire logic STANDBY_SEL,
  input wire logic TEST_N,
  // indicator outputs, open drain: pin low while oe high
  output logic LINK_GOOD_INDICATOR_OE,
  output logic BUS_ACTIVITY_INDICATOR_OE,
  output logic NETWORK_ACTIVITY_LED_OE,
  output logic NODE_ACTIVITY_LED_OE,
  // mode, wakeup and interrupt outputs
  output logic WAKEUP_OUTPUT,
  output logic SCAN_MODE,
  output logic SUSPEND,
  output logic STANDBY,
  output logic IRQ
);

  typedef struct packed {
    logic aw_got;
    logic [4:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [3:0] ctrl;
    logic [3:0] status;
    logic [3:0] mask;
    logic [22:0] net_cnt;
    logic [22:0] node_cnt;
    logic wake;
    logic link_q;
    logic sleep_q;
    logic test_q;
    sli_pkg::sli_mode_t mode;
    logic net_oe;
    logic node_oe;
    logic link_oe;
    logic bus_oe;
  } sli_state_t;

  sli_state_t st_r;
  sli_state_t st_nxt;

  localparam logic [22:0] PULSE_LOAD = 23'(PULSE_CYC);

  function automatic logic reg_hit(input logic [4:0] a, input logic [4:0] off);
    reg_hit = (a[4:2] == off[4:2]);
  endfunction

  function automatic logic [22:0] pulse_step(input logic [22:0] cnt,
                                             input logic trig);
    if (trig) begin
      pulse_step = PULSE_LOAD;
    end else if (cnt != 23'h000000) begin
      pulse_step = cnt - 23'h000001;
    end else begin
      pulse_step = 23'h000000;
    end
  endfunction

  logic [3:0] ev;
  logic net_trig;
  logic node_trig;
  logic do_write;
  logic do_read;

  always_comb begin
    st_nxt = st_r;
    net_trig = RX_PACKET | TX_PACKET | COLLISION;
    node_trig = RX_OWN_PACKET | TX_PACKET;
    // mode: scan overrides sleep; the sleep flavour is picked by a strap
    st_nxt.test_q = TEST_N;
    st_nxt.sleep_q = SLEEP_N;
    if (!TEST_N) begin
      st_nxt.mode = sli_pkg::SLI_SCAN;
    end else if (!SLEEP_N && STANDBY_SEL) begin
      st_nxt.mode = sli_pkg::SLI_STANDBY;
    end else begin
      st_nxt.mode = sli_pkg::SLI_RUN;
    end
    ev = 4'h0;
    ev[`SLI_IRQ_WAKE] = WAKE_FRAME & ~st_r.wake;
    ev[`SLI_IRQ_LINK] = LINK_PULSES_OK ^ st_r.link_q;
    ev[`SLI_IRQ_SLEEP] = st_r.sleep_q & ~SLEEP_N;
    ev[`SLI_IRQ_TEST] = st_r.test_q & ~TEST_N;
    st_nxt.link_q = LINK_PULSES_OK;
    // wakeup holds until software reads status; receiver stays live in standby
    if (WAKE_FRAME) begin
      st_nxt.wake = 1'b1;
    end
    // pulse timers retrigger; cleared in standby, scan and suspend
    if (st_r.mode == sli_pkg::SLI_RUN && SLEEP_N) begin
      st_nxt.net_cnt = pulse_step(st_r.net_cnt,
                                  net_trig);
      st_nxt.node_cnt = pulse_step(st_r.node_cnt,
                                   node_trig);
    end else begin
      st_nxt.net_cnt = 23'h000000;
      st_nxt.node_cnt = 23'h000000;
    end
    if (st_r.mode == sli_pkg::SLI_STANDBY) begin
      st_nxt.net_oe = RX_LINE_ACTIVE;
    end else begin
      st_nxt.net_oe = (st_nxt.net_cnt != 23'h000000);
    end
    st_nxt.node_oe = (st_nxt.node_cnt != 23'h000000);
    st_nxt.link_oe = st_r.ctrl[`SLI_CTRL_SEL0] ?
                     st_r.ctrl[`SLI_CTRL_VAL0] :
                     LINK_PULSES_OK;
    st_nxt.bus_oe = st_r.ctrl[`SLI_CTRL_SEL1] ?
                    st_r.ctrl[`SLI_CTRL_VAL1] :
                    RX_BUS_ACCESS;
    // axi4-lite slave: address and data taken in either order
    if (AWVALID && AWREADY) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.aw_addr = AWADDR;
    end
    if (WVALID && WREADY) begin
      st_nxt.w_got = 1'b1;
      st_nxt.w_data = WDATA;
      st_nxt.w_strb = WSTRB;
    end
    do_write = st_r.aw_got && st_r.w_got && !st_r.bvalid;
    if (do_write) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = 2'h0;
      if (reg_hit(st_r.aw_addr, `SLI_OFF_CTRL)) begin
        if (st_r.w_strb[0]) begin
          st_nxt.ctrl = st_r.w_data[3:0];
        end
      end else if (reg_hit(st_r.aw_addr, `SLI_OFF_MASK)) begin
        if (st_r.w_strb[0]) begin
          st_nxt.mask = st_r.w_data[3:0];
        end
      end else if (!reg_hit(st_r.aw_addr, `SLI_OFF_STATUS) &&
                   !reg_hit(st_r.aw_addr, `SLI_OFF_IRQ)) begin
        st_nxt.bresp = 2'h2;
      end
    end
    if (st_r.bvalid && BREADY) begin
      st_nxt.bvalid = 1'b0;
    end
    do_read = ARVALID && ARREADY;
    if (do_read) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = 2'h0;
      st_nxt.rdata = 32'h00000000;
      if (reg_hit(ARADDR, `SLI_OFF_CTRL)) begin
        st_nxt.rdata[3:0] = st_r.ctrl;
      end else if (reg_hit(ARADDR, `SLI_OFF_STATUS)) begin
        st_nxt.rdata[3:0] = st_r.status;
        st_nxt.status = 4'h0;
        st_nxt.wake = WAKE_FRAME;
      end else if (reg_hit(ARADDR, `SLI_OFF_MASK)) begin
        st_nxt.rdata[3:0] = st_r.mask;
      end else if (reg_hit(ARADDR, `SLI_OFF_IRQ)) begin
        st_nxt.rdata[2:0] = st_r.mode;
      end else begin
        st_nxt.rresp = 2'h2;
      end
    end
    if (st_r.rvalid && RREADY) begin
      st_nxt.rvalid = 1'b0;
    end
    // new events win over the clear-on-read
    st_nxt.status = st_nxt.status | ev;
  end

  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      st_r <= '0;
      st_r.ctrl <= `SLI_CTRL_RST;
      st_r.mask <= `SLI_MASK_RST;
      st_r.mode <= sli_pkg::SLI_RUN;
      st_r.sleep_q <= 1'b1;
      st_r.test_q <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // one outstanding write and one read; handshake outputs come straight from registered state
  assign AWREADY = !st_r.aw_got;
  assign WREADY = !st_r.w_got;
  assign BVALID = st_r.bvalid;
  assign BRESP = st_r.bresp;
  assign ARREADY = !st_r.rvalid;
  assign RVALID = st_r.rvalid;
  assign RDATA = st_r.rdata;
  assign RRESP = st_r.rresp;

  assign LINK_GOOD_INDICATOR_OE = st_r.link_oe;
  assign BUS_ACTIVITY_INDICATOR_OE = st_r.bus_oe;
  assign NETWORK_ACTIVITY_LED_OE = st_r.net_oe;
  assign NODE_ACTIVITY_LED_OE = st_r.node_oe;
  assign WAKEUP_OUTPUT = st_r.wake;
  assign SCAN_MODE = (st_r.mode == sli_pkg::SLI_SCAN);
  assign STANDBY = (st_r.mode == sli_pkg::SLI_STANDBY);
  assign SUSPEND = !st_r.sleep_q && (st_r.mode == sli_pkg::SLI_RUN);
  assign IRQ = |(st_r.status & st_r.mask);

  a_link_follow: assert property (@(posedge CLOCK)
    disable iff (RESET)
    !st_r.ctrl[`SLI_CTRL_SEL0] |=>
      LINK_GOOD_INDICATOR_OE == $past(LINK_PULSES_OK))
    else $error("link indicator does not follow link pulses");
  a_link_host: assert property (@(posedge CLOCK)
    disable iff (RESET)
    st_r.ctrl[`SLI_CTRL_SEL0] |=>
      LINK_GOOD_INDICATOR_OE == $past(st_r.ctrl[`SLI_CTRL_VAL0]))
    else $error("link indicator ignores host value");
  a_bus_follow: assert property (@(posedge CLOCK)
    disable iff (RESET)
    !st_r.ctrl[`SLI_CTRL_SEL1] |=>
      BUS_ACTIVITY_INDICATOR_OE == $past(RX_BUS_ACCESS))
    else $error("bus indicator does not follow bus access");
  a_bus_host: assert property (@(posedge CLOCK)
    disable iff (RESET)
    st_r.ctrl[`SLI_CTRL_SEL1] |=>
      BUS_ACTIVITY_INDICATOR_OE == $past(st_r.ctrl[`SLI_CTRL_VAL1]))
    else $error("bus indicator ignores host value");
  a_net_pulse: assert property (@(posedge CLOCK)
    disable iff (RESET)
    (st_r.mode == sli_pkg::SLI_RUN && SLEEP_N && TEST_N && RX_PACKET)
      |=> NETWORK_ACTIVITY_LED_OE && st_r.net_cnt == PULSE_LOAD)
    else $error("network led pulse not started");
  a_net_standby: assert property (@(posedge CLOCK)
    disable iff (RESET)
    st_r.mode == sli_pkg::SLI_STANDBY |=>
      NETWORK_ACTIVITY_LED_OE == $past(RX_LINE_ACTIVE))
    else $error("network led does not follow line in standby");
  a_node_pulse: assert property (@(posedge CLOCK)
    disable iff (RESET)
    (st_r.mode == sli_pkg::SLI_RUN && SLEEP_N && TX_PACKET)
      |=> NODE_ACTIVITY_LED_OE && st_r.node_cnt == PULSE_LOAD)
    else $error("node led pulse not started");
  a_wake_out: assert property (@(posedge CLOCK)
    disable iff (RESET)
    WAKE_FRAME |=> WAKEUP_OUTPUT)
    else $error("wakeup output missed a wakeup frame");
  a_scan_mode: assert property (@(posedge CLOCK)
    disable iff (RESET)
    !TEST_N |=> SCAN_MODE && !STANDBY)
    else $error("scan mode not entered");
  a_pulse_end: assert property (@(posedge CLOCK)
    disable iff (RESET)
    (st_r.net_cnt == 23'h000001 && !net_trig && st_r.mode == sli_pkg::SLI_RUN
     && SLEEP_N && TEST_N) |=> !NETWORK_ACTIVITY_LED_OE)
    else $error("network led pulse too long");

endmodule
`default_nettype wire

// File: sli_top_tb.sv
// self-checking bench of the status indicator block
`timescale 1ns/1ps
`default_nettype none
`include "sli_map.svh"
module sli_top_tb;
  logic clock = 0, reset = 1, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
  logic [4:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rdat, d;
  logic [1:0] bresp, rresp, r, b;
  logic awr, wr_r, bv, arr, rv;
  logic lnk = 0, bacc = 0, rxp = 0, own = 0, txp = 0, col = 0, act = 0;
  logic wake = 0, slp_n = 1, ssel = 0, tst_n = 1;
  logic lo, bo, no, do_, wk, scan, susp, stby, irq;
  logic lp, bp, np, dp;
  int errors = 0, n_checks = 0;
  sli_top #(.PULSE_CYC(20)) uut (.CLOCK(clock), .RESET(reset),
    .AWADDR(awa), .AWVALID(awv), .AWREADY(awr), .WDATA(wd),
    .WSTRB(4'hF), .WVALID(wv), .WREADY(wr_r), .BRESP(bresp), .BVALID(bv),
    .BREADY(bre), .ARADDR(ara), .ARVALID(arv), .ARREADY(arr),
    .RDATA(rdat), .RRESP(rresp), .RVALID(rv), .RREADY(rre),
    .LINK_PULSES_OK(lnk), .RX_BUS_ACCESS(bacc), .RX_PACKET(rxp),
    .RX_OWN_PACKET(own), .TX_PACKET(txp), .COLLISION(col),
    .RX_LINE_ACTIVE(act), .WAKE_FRAME(wake), .SLEEP_N(slp_n),
    .STANDBY_SEL(ssel), .TEST_N(tst_n), .LINK_GOOD_INDICATOR_OE(lo),
    .BUS_ACTIVITY_INDICATOR_OE(bo), .NETWORK_ACTIVITY_LED_OE(no),
    .NODE_ACTIVITY_LED_OE(do_), .WAKEUP_OUTPUT(wk), .SCAN_MODE(scan),
    .SUSPEND(susp), .STANDBY(stby), .IRQ(irq));
  sli_led_model pins (.link_oe(lo), .bus_oe(bo), .net_oe(no),
    .node_oe(do_), .link_pin(lp), .bus_pin(bp), .net_pin(np), .node_pin(dp));
  initial forever #5 clock = ~clock;
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // settle n edges, then look between edges where nothing moves
  task at(input int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask
  task wr(input logic [4:0] a, input logic [31:0] v);
    logic ta, tw, tb;
    @(posedge clock);
    awa <= a;
    wd <= v;
    awv <= 1;
    wv <= 1;
    bre <= 1;
    forever begin
      @(negedge clock);
      ta = awv & awr;
      tw = wv & wr_r;
      tb = bv;
      b = bresp;
      @(posedge clock);
      if (ta) awv <= 0;
      if (tw) wv <= 0;
      if (tb) begin
        bre <= 0;
        return;
      end
    end
  endtask
  task rd(input logic [4:0] a);
    logic ta, tr;
    @(posedge clock);
    ara <= a;
    arv <= 1;
    rre <= 1;
    forever begin
      @(negedge clock);
      ta = arv & arr;
      tr = rv;
      d = rdat;
      r = rresp;
      @(posedge clock);
      if (ta) arv <= 0;
      if (tr) begin
        rre <= 0;
        return;
      end
    end
  endtask
  task t_ind;
    for (int j = 0; j < 2; j++) begin
      @(posedge clock) {bacc, lnk} <= 2'b01 << j;
      at(3);
      chk(j ? bp : lp, 0);
      @(posedge clock) {bacc, lnk} <= 2'b00;
      at(3);
      chk(j ? bp : lp, 1);
      @(posedge clock) {bacc, lnk} <= 2'b01 << j;
      wr(`SLI_OFF_CTRL, 32'h1 << (2 * j));
      at(3);
      chk(j ? bp : lp, 1);
      wr(`SLI_OFF_CTRL, 32'h3 << (2 * j));
      at(3);
      chk(j ? bp : lp, 0);
      wr(`SLI_OFF_CTRL, 0);
      @(posedge clock) {bacc, lnk} <= 2'b00;
    end
    $display("indicator test done");
  endtask
  task t_pulse;
    for (int i = 0; i < 4; i++) begin
      @(posedge clock) {rxp, own, txp, col} <= 4'b1000 >> i;
      @(posedge clock) {rxp, own, txp, col} <= 4'b0000;
      at(3);
      chk(np, (i == 1) ? 1 : 0);
      chk(dp, (i == 1 || i == 2) ? 0 : 1);
      at(14);
      @(posedge clock) txp <= 1;
      @(posedge clock) txp <= 0;
      at(14);
      chk({np, dp}, 0);
      at(10);
      chk({np, dp}, 2'b11);
    end
    $display("pulse test done");
  endtask
  task t_sleep;
    @(posedge clock);
    slp_n <= 0;
    ssel <= 1;
    act <= 1;
    at(3);
    chk({stby, susp, np}, 3'b100);
    @(posedge clock) act <= 0;
    at(3);
    chk(np, 1);
    @(posedge clock) ssel <= 0;
    at(3);
    chk({stby, susp}, 2'b01);
    @(posedge clock) slp_n <= 1;
    @(posedge clock) tst_n <= 0;
    at(3);
    chk(scan, 1);
    rd(`SLI_OFF_IRQ);
    chk(d, 4);
    @(posedge clock) tst_n <= 1;
    at(3);
    chk({scan, susp, stby}, 0);
    // link, sleep and test events since the last clear, no wakeup
    rd(`SLI_OFF_STATUS);
    chk(d, 32'h0000000E);
    $display("mode test done");
  endtask
  task t_wake;
    rd(`SLI_OFF_CTRL);
    chk(r, 0);
    chk(d, 0);
    rd(5'h10);
    chk(r, 2'b10);
    wr(5'h10, 1);
    chk(b, 2'b10);
    wr(`SLI_OFF_MASK, 1);
    chk(b, 0);
    @(posedge clock) wake <= 1;
    @(posedge clock) wake <= 0;
    at(3);
    chk({wk, irq}, 2'b11);
    rd(`SLI_OFF_STATUS);
    chk(d[0], 1);
    at(2);
    chk({wk, irq}, 0);
    wr(`SLI_OFF_MASK, 0);
    @(posedge clock) wake <= 1;
    @(posedge clock) wake <= 0;
    at(3);
    chk({wk, irq}, 2'b10);
    rd(`SLI_OFF_STATUS);
    chk(d, 1);
    $display("wakeup test done");
  endtask
  task results;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // the whole run needs a few hundred cycles
  initial begin
    #200000;
    errors++;
    results;
  end
  initial begin
    repeat (4) @(posedge clock);
    reset <= 0;
    t_wake;
    t_ind;
    t_pulse;
    t_sleep;
    results;
  end
endmodule
`default_nettype wire
